// File: rtl/mss_sequencer.sv
// Purpose: internally controlled sixteen-segment speed program sequencer
// Assumes: commands are synchronous one-cycle or level inputs on clk
// Notes:   outputs lag the sequencer state by one clock
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module mss_sequencer #(
	parameter int TICK_CYCLES = mss_pkg::TICK_CYCLES
) (
	input  wire logic                                 clk,           // system clock
	input  wire logic                                 rst_n,         // async reset, low
	input  wire logic [mss_pkg::ADDR_W-1:0]           regAddr,       // register byte address
	input  wire logic [mss_pkg::DATA_W-1:0]           regWdata,      // register write data
	input  wire logic                                 regWrite,      // write strobe
	input  wire logic                                 regRead,       // read strobe
	output logic      [mss_pkg::DATA_W-1:0]           regRdata,      // read data, next cycle
	input  wire logic                                 runCmd,        // run command
	input  wire logic                                 stopCmd,       // stop command
	input  wire logic                                 extFault,      // external fault
	input  wire logic                                 emergencyStop, // emergency stop
	output logic                                      outRunning,    // output active
	output logic      [mss_pkg::SEG_W-1:0]            outSegment,    // current segment
	output logic      [mss_pkg::FREQ_W-1:0]           outFreq,       // target frequency
	output logic                                      outReverse,    // reverse rotation
	output logic      [mss_pkg::RAMP_CODE_W-1:0]      outRampSel,    // ramp time pair
	output logic                                      cycleDone      // program finished
);
	import mss_pkg::*;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [MODE_W-1:0]    segmentModeSelect;
	logic [RUNMODE_W-1:0] runModeSelect;
	logic [DIR_W-1:0]     directionLowGroup;
	logic [DIR_W-1:0]     directionHighGroup;
	logic [RAMP_W-1:0]    rampSelectLowGroup;
	logic [RAMP_W-1:0]    rampSelectHighGroup;
	logic [FREQ_W-1:0]    freqTable [SEG_N];
	logic [TIME_W-1:0]    timerTable [SEG_N];

	logic [TSEL_W-1:0]    tableSel;
	logic [SEG_W-1:0]     tableIdx;
	logic                 aligned;
	logic [DATA_W-1:0]    readWord;

	assign tableSel = regAddr[ADDR_W-1 -: TSEL_W];
	assign tableIdx = regAddr[TBL_IDX_LSB +: SEG_W];
	assign aligned  = (regAddr[TBL_IDX_LSB-1:0] == '0);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			segmentModeSelect   <= MODE_SEL_RST;
			runModeSelect       <= RUNMODE_RST;
			directionLowGroup   <= DIR_RST;
			directionHighGroup  <= DIR_RST;
			rampSelectLowGroup  <= RAMP_RST;
			rampSelectHighGroup <= RAMP_RST;
		end
		else if (regWrite)
		begin
			case (regAddr)
				OFS_CTRL:
				begin
					segmentModeSelect <= regWdata[CTRL_MODE_LSB +: MODE_W];
					runModeSelect     <= regWdata[CTRL_RUNMODE_LSB +: RUNMODE_W];
				end
				OFS_DIR_LO:  directionLowGroup   <= regWdata[DIR_W-1:0];
				OFS_DIR_HI:  directionHighGroup  <= regWdata[DIR_W-1:0];
				OFS_RAMP_LO: rampSelectLowGroup  <= regWdata[RAMP_W-1:0];
				OFS_RAMP_HI: rampSelectHighGroup <= regWdata[RAMP_W-1:0];
				default:;
			endcase
		end
	end

	// setpoint and timer tables, index 0 holds the main setpoint
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < SEG_N; i++)
			begin
				freqTable[i]  <= '0;
				timerTable[i] <= '0;
			end
		end
		else if (regWrite && aligned)
		begin
			if (tableSel == TSEL_FREQ)
				freqTable[tableIdx] <= regWdata[FREQ_W-1:0];
			else if (tableSel == TSEL_TIMER)
				timerTable[tableIdx] <= regWdata[TIME_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	mss_seg_if  sif ();
	mss_state_t state;
	mss_state_t next_state;
	logic [SEG_W-1:0]     segIndex;
	logic [SEG_W-1:0]     next_seg;
	logic [RUNMODE_W-1:0] latchedRunMode;
	logic [SEG_N-1:0]     usedMask;
	logic [SEG_W-1:0]     nextSeg;
	logic [SEG_W-1:0]     firstSeg;
	logic                 wrapped;
	logic                 modeInternal;
	logic                 abort;
	logic                 startOk;
	logic                 finish;
	logic                 running;
	logic [FREQ_W-1:0]    curFreq;

	// first used segment after 'from', wrapping; 'from' itself when none
	function automatic logic [SEG_W-1:0] seekUsed(
		input logic [SEG_N-1:0] mask,
		input logic [SEG_W-1:0] from
	);
		logic [SEG_W-1:0] probe;
		logic             found;
		seekUsed = from;
		found    = 1'b0;
		for (int i = 1; i <= SEG_N; i++)
		begin
			probe = from + SEG_W'(i);
			if (!found && mask[probe])
			begin
				seekUsed = probe;
				found    = 1'b1;
			end
		end
	endfunction

	always_comb
	begin
		for (int i = 0; i < SEG_N; i++)
			usedMask[i] = (timerTable[i] != '0);
	end

	assign nextSeg      = seekUsed(usedMask, segIndex);
	assign firstSeg     = seekUsed(usedMask, SEG_LAST);
	assign wrapped      = (nextSeg <= segIndex);
	assign modeInternal = (segmentModeSelect == MODE_INTERNAL);
	// stop, fault and emergency stop are the only commands obeyed while running
	assign abort        = stopCmd || extFault || emergencyStop || !modeInternal;
	assign startOk      = runCmd && !abort && (usedMask != '0);
	assign running      = (state == SEQ_RUN) && modeInternal;
	assign curFreq      = freqTable[segIndex];

	always_comb
	begin
		next_state     = state;
		next_seg       = segIndex;
		sif.timerLoad  = 1'b0;
		sif.timerValue = timerTable[segIndex];
		finish         = 1'b0;
		unique case (state)
			SEQ_IDLE:
				if (startOk)
				begin
					next_state     = SEQ_RUN;
					next_seg       = firstSeg;
					sif.timerLoad  = 1'b1;
					sif.timerValue = timerTable[firstSeg];
				end
			SEQ_RUN:
				if (abort)
					next_state = SEQ_IDLE;
				else if (sif.timerExpired)
				begin
					if (wrapped && !latchedRunMode[RUNMODE_CIRC_BIT])
					begin
						next_state = SEQ_IDLE;
						finish     = 1'b1;
					end
					else if (latchedRunMode[RUNMODE_STOP_BIT])
					begin
						next_state     = SEQ_PAUSE;
						next_seg       = nextSeg;
						sif.timerLoad  = 1'b1;
						sif.timerValue = STOP_PAUSE_TICKS;
					end
					else
					begin
						next_seg       = nextSeg;
						sif.timerLoad  = 1'b1;
						sif.timerValue = timerTable[nextSeg];
					end
				end
			SEQ_PAUSE:
				if (abort)
					next_state = SEQ_IDLE;
				else if (sif.timerExpired)
				begin
					next_state    = SEQ_RUN;
					sif.timerLoad = 1'b1;
				end
			default: next_state = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= SEQ_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			segIndex <= '0;
		else
			segIndex <= next_seg;
	end

	// run mode is frozen at start so CTRL writes cannot change the run mode of a running program
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			latchedRunMode <= RUNMODE_RST;
		else if (state == SEQ_IDLE && startOk)
			latchedRunMode <= runModeSelect;
	end

	assign sif.segIndex = segIndex;
	assign sif.dirLow   = directionLowGroup;
	assign sif.dirHigh  = directionHighGroup;
	assign sif.rampLow  = rampSelectLowGroup;
	assign sif.rampHigh = rampSelectHighGroup;
	assign sif.timerRun = (state != SEQ_IDLE);

	mss_seg_lookup u_lookup (
		.sif (sif.lookup)
	);

	mss_seg_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.sif   (sif.timer)
	);

	// ----------------------------------------------------------------
	// outputs and read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			outRunning <= 1'b0;
			outSegment <= '0;
			outFreq    <= '0;
			outReverse <= 1'b0;
			outRampSel <= '0;
			cycleDone  <= 1'b0;
		end
		else
		begin
			outRunning <= running;
			outSegment <= segIndex;
			outFreq    <= running ? curFreq : '0;
			outReverse <= running && sif.reverse;
			outRampSel <= running ? sif.rampSel : '0;
			cycleDone  <= finish;
		end
	end

	always_comb
	begin
		readWord = '0;
		if (aligned && tableSel == TSEL_FREQ)
			readWord = DATA_W'(freqTable[tableIdx]);
		else if (aligned && tableSel == TSEL_TIMER)
			readWord = DATA_W'(timerTable[tableIdx]);
		else
		begin
			case (regAddr)
				OFS_CTRL:
				begin
					readWord[CTRL_MODE_LSB +: MODE_W]       = segmentModeSelect;
					readWord[CTRL_RUNMODE_LSB +: RUNMODE_W] = runModeSelect;
				end
				OFS_STATUS:
				begin
					readWord[STAT_STATE_LSB +: $bits(state)] = state;
					readWord[STAT_SEG_LSB +: SEG_W]          = segIndex;
					readWord[STAT_RUN_BIT]                   = running;
				end
				OFS_DIR_LO:  readWord = DATA_W'(directionLowGroup);
				OFS_DIR_HI:  readWord = DATA_W'(directionHighGroup);
				OFS_RAMP_LO: readWord = DATA_W'(rampSelectLowGroup);
				OFS_RAMP_HI: readWord = DATA_W'(rampSelectHighGroup);
				default:     readWord = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			regRdata <= '0;
		else
			regRdata <= regRead ? readWord : '0;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [2*DIR_W-1:0]  dirAll;
	logic [2*RAMP_W-1:0] rampAll;
	assign dirAll  = {directionHighGroup, directionLowGroup};
	assign rampAll = {rampSelectHighGroup, rampSelectLowGroup};

	a_mode_gate: assert property (
		state != SEQ_IDLE && !modeInternal |=> state == SEQ_IDLE)
		else $error("program kept running outside internal mode");
	a_single_stop: assert property (
		state == SEQ_RUN && !abort && sif.timerExpired && wrapped
		&& !latchedRunMode[RUNMODE_CIRC_BIT] |=> state == SEQ_IDLE && cycleDone)
		else $error("single pass did not stop after the last segment");
	a_circ_hold: assert property (
		state != SEQ_IDLE && latchedRunMode[RUNMODE_CIRC_BIT] && !abort
		|=> state != SEQ_IDLE)
		else $error("circular program stopped without a stop command");
	a_pause_step: assert property (
		state == SEQ_RUN && !abort && sif.timerExpired && latchedRunMode[RUNMODE_STOP_BIT]
		&& !(wrapped && !latchedRunMode[RUNMODE_CIRC_BIT])
		|=> state == SEQ_PAUSE ##1 !outRunning)
		else $error("segment boundary did not halt the output");
	a_freq_source: assert property (
		running && $stable(segIndex) |=> outFreq == $past(curFreq) && outRunning)
		else $error("frequency not taken from the segment setpoint");
	a_seg_advance: assert property (
		state == SEQ_RUN && !abort && sif.timerExpired
		&& !(wrapped && !latchedRunMode[RUNMODE_CIRC_BIT])
		|=> segIndex == $past(nextSeg))
		else $error("segment did not advance on timer expiry");
	a_skip_unused: assert property (
		state == SEQ_RUN && sif.timerExpired && usedMask != '0 |-> usedMask[nextSeg])
		else $error("next segment has a zero timer");
	a_dir_lookup: assert property (
		sif.reverse == dirAll[segIndex])
		else $error("direction bit taken from the wrong position");
	a_ramp_lookup: assert property (
		sif.rampSel == rampAll[{segIndex, 1'b0} +: RAMP_CODE_W])
		else $error("ramp code taken from the wrong pair");
	a_gate_idle: assert property (
		!modeInternal |=> !outReverse && outRampSel == '0 && !outRunning)
		else $error("direction or ramp applied outside internal mode");

	c_single_done: cover property (cycleDone);
	c_pause_resume: cover property (state == SEQ_PAUSE ##1 state == SEQ_RUN);
	c_circ_wrap: cover property (
		state == SEQ_RUN && sif.timerExpired && wrapped && latchedRunMode[RUNMODE_CIRC_BIT]);
endmodule

// File: include/mss_pkg.sv
// Purpose: shared constants and types of the multi-segment speed sequencer
// Assumes: 40 MHz system clock, 32-bit register port
// Notes:   register offsets are byte addresses on the plain register port
package mss_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W      = 8;
	localparam int DATA_W      = 32;
	localparam int SEG_N       = 16;
	localparam int SEG_W       = 4;
	localparam int FREQ_W      = 17;
	localparam int TIME_W      = 16;
	localparam int DIR_W       = 8;
	localparam int RAMP_W      = 16;
	localparam int RAMP_CODE_W = 2;
	localparam int MODE_W      = 3;
	localparam int RUNMODE_W   = 2;
	localparam int TSEL_W      = 2;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_DIR_LO   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_DIR_HI   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_RAMP_LO  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_RAMP_HI  = 8'h14;
	// tables: frequency words at 8'h40..8'h7C, timer words at 8'h80..8'hBC
	localparam logic [TSEL_W-1:0] TSEL_REGS    = 2'h0;
	localparam logic [TSEL_W-1:0] TSEL_FREQ    = 2'h1;
	localparam logic [TSEL_W-1:0] TSEL_TIMER   = 2'h2;
	localparam int                TBL_IDX_LSB  = 2;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int                   CTRL_MODE_LSB    = 0;
	localparam int                   CTRL_RUNMODE_LSB = 4;
	localparam int                   STAT_STATE_LSB   = 0;
	localparam int                   STAT_SEG_LSB     = 4;
	localparam int                   STAT_RUN_BIT     = 8;
	localparam logic [MODE_W-1:0]    MODE_INTERNAL    = 3'h1;
	localparam logic [MODE_W-1:0]    MODE_SEL_RST     = 3'h2;
	localparam logic [RUNMODE_W-1:0] RUNMODE_RST      = 2'h0;
	localparam int                   RUNMODE_CIRC_BIT = 0;
	localparam int                   RUNMODE_STOP_BIT = 1;
	localparam logic [DIR_W-1:0]     DIR_RST          = 8'h00;
	localparam logic [RAMP_W-1:0]    RAMP_RST         = 16'h0000;
	localparam logic [SEG_W-1:0]     SEG_LAST         = 4'hF;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int                CLK_PERIOD_NS    = 25;
	localparam int                TIMER_UNIT_NS    = 100_000_000;
	localparam int                TICK_CYCLES      = TIMER_UNIT_NS / CLK_PERIOD_NS;
	localparam logic [TIME_W-1:0] STOP_PAUSE_TICKS = 16'h0001;

	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_RUN   = 2'b01,
		SEQ_PAUSE = 2'b10
	} mss_state_t;
endpackage

// File: include/mss_seg_if.sv
// Purpose: carries segment index, lookup results and timer handshake
// Assumes: one clock domain
// Notes:   seq drives, lookup and timer answer
`timescale 1ns/100ps
interface mss_seg_if;
	import mss_pkg::*;
	logic [SEG_W-1:0]       segIndex;
	logic [DIR_W-1:0]       dirLow;
	logic [DIR_W-1:0]       dirHigh;
	logic [RAMP_W-1:0]      rampLow;
	logic [RAMP_W-1:0]      rampHigh;
	logic                   reverse;
	logic [RAMP_CODE_W-1:0] rampSel;
	logic                   timerLoad;
	logic [TIME_W-1:0]      timerValue;
	logic                   timerRun;
	logic                   timerExpired;

	modport seq (
		output segIndex, dirLow, dirHigh, rampLow, rampHigh,
		output timerLoad, timerValue, timerRun,
		input  reverse, rampSel, timerExpired
	);
	modport lookup (
		input  segIndex, dirLow, dirHigh, rampLow, rampHigh,
		output reverse, rampSel
	);
	modport timer (
		input  timerLoad, timerValue, timerRun,
		output timerExpired
	);
endinterface

// File: rtl/mss_seg_lookup.sv
// Purpose: picks direction bit and ramp set code of the current segment
// Assumes: index below eight uses the low group words
// Notes:   purely combinational
`timescale 1ns/100ps
module mss_seg_lookup (
	mss_seg_if.lookup sif // segment index in, direction and ramp code out
);
	import mss_pkg::*;

	logic [DIR_W-1:0]  dirWord;
	logic [RAMP_W-1:0] rampWord;
	logic [SEG_W-2:0]  slot;

	assign slot     = sif.segIndex[SEG_W-2:0];
	assign dirWord  = sif.segIndex[SEG_W-1] ? sif.dirHigh : sif.dirLow;
	assign rampWord = sif.segIndex[SEG_W-1] ? sif.rampHigh : sif.rampLow;

	// bit 0 is the first segment of the group, set means reverse
	assign sif.reverse = dirWord[slot];

	// code 0..3 selects ramp pair one..four, first segment in the low pair
	assign sif.rampSel = rampWord[{slot, 1'b0} +: RAMP_CODE_W];
endmodule

// File: rtl/mss_seg_timer.sv
// Purpose: segment duration countdown in 0.1 s ticks
// Assumes: timerLoad and timerRun come from the sequencer
// Notes:   a loaded zero expires on the first tick
`timescale 1ns/100ps
module mss_seg_timer #(
	parameter int TICK_CYCLES = mss_pkg::TICK_CYCLES
) (
	input wire logic  clk,   // system clock
	input wire logic  rst_n, // asynchronous reset, active low
	mss_seg_if.timer  sif    // load, run and expiry
);
	import mss_pkg::*;

	localparam int PRE_W = $clog2(TICK_CYCLES + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
	localparam logic [TIME_W-1:0] REMAIN_LAST = TIME_W'(1);

	logic [PRE_W-1:0]  preCount;
	logic [TIME_W-1:0] remain;
	logic              tick;

	assign tick = sif.timerRun && (preCount == PRE_LAST);

	// prescaler restarts on every load so a segment lasts whole ticks
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			preCount <= '0;
		else if (sif.timerLoad || !sif.timerRun || tick)
			preCount <= '0;
		else
			preCount <= preCount + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			remain <= '0;
		else if (sif.timerLoad)
			remain <= sif.timerValue;
		else if (tick && remain != '0)
			remain <= remain - 1'b1;
	end

	assign sif.timerExpired = tick && (remain <= REMAIN_LAST);
endmodule

// File: verification/mss_cmd_source.sv
// Purpose: operator panel model that issues run and stop commands
// Assumes: one request per fire pulse, kind 0 run, 1 stop, 2 fault, 3 estop
// Notes:   each command is a one-cycle pulse launched on the clock edge
`timescale 1ns/100ps
module mss_cmd_source (
	input wire logic       clk,           // system clock
	input wire logic       fire,          // request strobe from the bench
	input wire logic [1:0] kind,          // which command to issue
	output logic           runCmd,        // run command
	output logic           stopCmd,       // stop command
	output logic           extFault,      // external fault
	output logic           emergencyStop  // emergency stop
);
	initial
	begin
		{runCmd, stopCmd, extFault, emergencyStop} = 4'h0;
	end
	always @(posedge clk)
	begin
		runCmd        <= fire && kind == 2'h0;
		stopCmd       <= fire && kind == 2'h1;
		extFault      <= fire && kind == 2'h2;
		emergencyStop <= fire && kind == 2'h3;
	end
endmodule

// File: verification/multi_segment_speed_sequencer_tb.sv
// Purpose: self-checking bench of the multi-segment speed sequencer
// Assumes: TICK_CYCLES shortened to 4 clocks per tick
// Notes:   segment lengths allow one clock of slack for the output register
`timescale 1ns/100ps
module multi_segment_speed_sequencer_tb;
	import mss_pkg::*;
	localparam int TK = 4;
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic [ADDR_W-1:0]      regAddr = '0;
	logic [DATA_W-1:0]      regWdata = '0;
	logic                   regWrite = 1'b0;
	logic                   regRead = 1'b0;
	logic [DATA_W-1:0]      regRdata;
	logic                   runCmd, stopCmd, extFault, emergencyStop;
	logic                   fire = 1'b0;
	logic [1:0]             kind = 2'h0;
	logic                   outRunning, outReverse, cycleDone;
	logic [SEG_W-1:0]       outSegment, curSeg;
	logic [FREQ_W-1:0]      outFreq;
	logic [RAMP_CODE_W-1:0] outRampSel;
	logic [FREQ_W-1:0]      frq[SEG_N];
	logic [15:0]            dirw;
	logic [31:0]            rampw;
	int                     tim[SEG_N];
	int                     n_mismatch = 0;
	int                     check_count = 0;
	int                     nz, nEnt, falls, segCyc, s, lenC;
	bit                     fresh, durOn, prevRun;

	always #12.5 clk = ~clk;

	mss_sequencer #(.TICK_CYCLES(TK)) dut_u (
		.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.runCmd(runCmd), .stopCmd(stopCmd), .extFault(extFault),
		.emergencyStop(emergencyStop), .outRunning(outRunning),
		.outSegment(outSegment), .outFreq(outFreq), .outReverse(outReverse),
		.outRampSel(outRampSel), .cycleDone(cycleDone)
	);
	mss_cmd_source op_u (
		.clk(clk), .fire(fire), .kind(kind), .runCmd(runCmd), .stopCmd(stopCmd),
		.extFault(extFault), .emergencyStop(emergencyStop)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic end_sim();
		if (n_mismatch == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 chk(regRdata, exp);
	endtask
	task automatic cmd(input logic [1:0] k);
		@(posedge clk);
		fire <= 1'b1;
		kind <= k;
		@(posedge clk);
		fire <= 1'b0;
	endtask
	// next segment with a nonzero timer, wrapping after the last one
	function automatic int nxt(input int a);
		for (int i = 1; i <= SEG_N; i++)
			if (tim[(a + i) % SEG_N] != 0)
				return (a + i) % SEG_N;
		return a;
	endfunction
	task automatic segEnd();
		if (durOn)
			chk(32'(segCyc >= tim[curSeg] * TK - 1 && segCyc <= tim[curSeg] * TK + 1), 32'h1);
	endtask

	// ----------------------------------------------------------------
	// output monitor
	// ----------------------------------------------------------------
	always @(negedge clk)
	begin
		s = int'(outSegment);
		if (rst_n && outRunning === 1'b1)
		begin
			if (!prevRun || outSegment !== curSeg)
			begin
				if (prevRun)
					segEnd();
				chk(32'(outSegment), 32'(fresh ? nxt(SEG_N - 1) : nxt(int'(curSeg))));
				curSeg = outSegment;
				fresh = 1'b0;
				nEnt++;
				segCyc = 0;
			end
			segCyc++;
			chk(32'(outFreq), 32'(frq[s]));
			chk(32'(outReverse), 32'(dirw[s]));
			chk(32'(outRampSel), 32'(rampw[2 * s +: 2]));
		end
		else if (rst_n)
		begin
			if (prevRun)
			begin
				segEnd();
				falls++;
			end
			chk(32'({outFreq, outReverse, outRampSel}), 32'h0);
		end
		prevRun = rst_n && outRunning === 1'b1;
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic run(input int rm, input logic [1:0] k);
		wr(OFS_CTRL, 32'h1 | (32'(rm) << 4));
		fresh = 1'b1;
		durOn = 1'b1;
		nEnt = 0;
		falls = 0;
		cmd(2'h0);
		if (rm[0] == 1'b0)
		begin
			for (int i = 0; i < 3000 && cycleDone !== 1'b1; i++)
				@(negedge clk);
			chk(32'(cycleDone), 32'h1);
			repeat (30) @(negedge clk);
			chk(32'(nEnt), 32'(nz));
			chk(32'(falls), 32'(rm == 2 ? nz : 1));
		end
		else
		begin
			repeat (lenC) @(negedge clk);
			cmd(2'h0);
			repeat (10) @(negedge clk);
			durOn = 1'b0;
			cmd(k);
			repeat (4) @(negedge clk);
			chk(32'(outRunning), 32'h0);
			chk(32'(nEnt > nz), 32'h1);
		end
	endtask

	initial
	begin
		fork
			begin
				#2_000_000;
				n_mismatch++;
				end_sim();
			end
		join_none
		void'($urandom(32'h0a1d980c));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_CTRL, 32'(MODE_SEL_RST));
		for (int a = 4; a <= 20; a += 4)
			rd(8'(a), 32'h0);
		rd(8'hFC, 32'h0);
		dirw = 16'($urandom);
		rampw = $urandom;
		wr(OFS_DIR_LO, {24'($urandom), dirw[7:0]});
		wr(OFS_DIR_HI, {24'($urandom), dirw[15:8]});
		wr(OFS_RAMP_LO, {16'($urandom), rampw[15:0]});
		wr(OFS_RAMP_HI, {16'($urandom), rampw[31:16]});
		rd(OFS_DIR_HI, {24'h0, dirw[15:8]});
		rd(OFS_RAMP_HI, {16'h0, rampw[31:16]});
		nz = 0;
		lenC = 40;
		for (int i = 0; i < SEG_N; i++)
		begin
			frq[i] = 17'($urandom);
			tim[i] = (i == 0) ? 1 : (i == 3) ? 0 : (i == 15) ? 2 : $urandom_range(0, 2);
			nz += (tim[i] != 0) ? 1 : 0;
			lenC += 2 * TK * (tim[i] + 2);
			wr(8'h40 + 8'(4 * i), 32'(frq[i]));
			wr(8'h80 + 8'(4 * i), 32'(tim[i]));
		end
		// an unaligned table write must leave the main setpoint alone
		wr(8'h41, 32'(~frq[0]));
		rd(8'h40, 32'(frq[0]));
		rd(8'h41, 32'h0);
		nEnt = 0;
		cmd(2'h0);
		repeat (20) @(negedge clk);
		chk(32'(nEnt), 32'h0);
		run(0, 2'h1);
		run(0, 2'h1);
		run(2, 2'h1);
		run(1, 2'h1);
		run(3, 2'h2);
		run(1, 2'h3);
		// leaving internal control aborts a running program
		wr(OFS_CTRL, 32'h11);
		fresh = 1'b1;
		durOn = 1'b1;
		cmd(2'h0);
		repeat (lenC) @(negedge clk);
		durOn = 1'b0;
		wr(OFS_CTRL, 32'h10);
		repeat (4) @(negedge clk);
		chk(32'(outRunning), 32'h0);
		end_sim();
	end
endmodule
